// [shared/lane_mux_pkg.sv]
// Package: register map, select codes and lane word carrier for the lane mux
package lane_mux_pkg;

	// ==========================================================
	// Geometry
	localparam int unsigned LANE_COUNT = 4;
	localparam int unsigned DATA_WIDTH = 16;
	localparam int unsigned SEL_WIDTH  = 4;

	// ==========================================================
	// Register port
	localparam int unsigned ADDR_WIDTH = 8;
	localparam int unsigned BUS_WIDTH  = 32;
	localparam logic [7:0]  ADDR_SEL   = 8'h00;
	localparam logic [7:0]  ADDR_STAT  = 8'h04;
	localparam logic [15:0] SEL_RESET  = 16'h0000;

	// Status layout: active lanes low, refused lanes next
	localparam int unsigned STAT_ACTIVE_LSB  = 0;
	localparam int unsigned STAT_REFUSED_LSB = 4;

	// ==========================================================
	// Per-lane source codes; anything else leaves the lane idle
	localparam logic [3:0] SEL_IDLE  = 4'h0;
	localparam logic [3:0] SEL_PCIE  = 4'h1;
	localparam logic [3:0] SEL_SATA  = 4'h2;
	localparam logic [3:0] SEL_DP    = 4'h3;
	localparam logic [3:0] SEL_USB0  = 4'h4;
	localparam logic [3:0] SEL_USB1  = 4'h5;
	localparam logic [3:0] SEL_SGMII = 4'h6;

	// ==========================================================
	// One parallel word towards or from a transceiver lane
	typedef struct packed {
		logic                  valid;
		logic [DATA_WIDTH-1:0] data;
	} lane_word_t;

	typedef logic [SEL_WIDTH-1:0] lane_sel_t;

endpackage : lane_mux_pkg

// [rtl/high_speed_lane_mux.sv]
// Module: routes serial peripheral controllers onto four transceiver lanes
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module high_speed_lane_mux (
	input  wire logic                                 clk,        // 20 MHz
	input  wire logic                                 rst,        // Sync, high
	input  wire logic [lane_mux_pkg::ADDR_WIDTH-1:0]  regAddr,    // Byte addr
	input  wire logic [lane_mux_pkg::BUS_WIDTH-1:0]   regWdata,   // Write data
	input  wire logic                                 regWr,      // Write strobe
	input  wire logic                                 regRd,      // Read strobe
	output logic      [lane_mux_pkg::BUS_WIDTH-1:0]   regRdata,   // Read data
	input  wire lane_mux_pkg::lane_word_t [3:0]       pcieTx,     // PCIe lanes
	input  wire lane_mux_pkg::lane_word_t [1:0]       sataTx,     // SATA chans
	input  wire lane_mux_pkg::lane_word_t [1:0]       dpTx,       // DP lanes
	input  wire lane_mux_pkg::lane_word_t [1:0]       usbTx,      // USB3 ctrls
	input  wire lane_mux_pkg::lane_word_t [3:0]       sgmiiTx,    // SGMII ports
	output lane_mux_pkg::lane_word_t      [3:0]       pcieRx,     // PCIe lanes
	output lane_mux_pkg::lane_word_t      [1:0]       sataRx,     // SATA chans
	output lane_mux_pkg::lane_word_t      [1:0]       usbRx,      // USB3 ctrls
	output lane_mux_pkg::lane_word_t      [3:0]       sgmiiRx,    // SGMII ports
	output lane_mux_pkg::lane_word_t      [3:0]       laneTx,     // To lanes
	input  wire lane_mux_pkg::lane_word_t [3:0]       laneRx,     // From lanes
	output logic      [3:0]                           laneActive  // Lane in use
);

	// ==========================================================
	// Configuration register and register port
	lane_mux_pkg::lane_sel_t [3:0]            sel_q;
	logic [lane_mux_pkg::BUS_WIDTH-1:0]       rdata_q;
	logic [3:0]                               laneLegal;
	logic [3:0]                               laneRefused;

	always_ff @(posedge clk) begin
		if (rst) begin
			sel_q <= lane_mux_pkg::SEL_RESET;
		end else if (regWr && regAddr == lane_mux_pkg::ADDR_SEL) begin
			sel_q <= regWdata[15:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= '0;
		end else if (regRd) begin
			unique case (regAddr)
				lane_mux_pkg::ADDR_SEL: begin
					rdata_q <= {16'h0000, sel_q};
				end
				lane_mux_pkg::ADDR_STAT: begin
					rdata_q <= {24'h00_0000, laneRefused, laneActive};
				end
				default: begin
					rdata_q <= '0;
				end
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	assign regRdata = rdata_q;

	// ==========================================================
	// Lane permission and transmit selection
	lane_mux_pkg::lane_word_t [3:0] laneTxD;
	logic                     [1:0] sataSeen;
	logic                     [1:0] dpSeen;
	logic                           usb0Seen;

	always_comb begin
		laneTxD     = '0;
		laneLegal   = '0;
		laneRefused = '0;
		sataSeen    = '0;
		dpSeen      = '0;
		usb0Seen    = 1'b0;
		for (int l = 0; l < 4; l++) begin
			case (sel_q[l])
				lane_mux_pkg::SEL_PCIE: begin
					laneLegal[l] = 1'b1;
					laneTxD[l]   = pcieTx[l];
				end
				lane_mux_pkg::SEL_SATA: begin
					// Lane parity picks the channel; a channel owns one lane
					if (!sataSeen[l%2]) begin
						laneLegal[l]   = 1'b1;
						sataSeen[l%2]  = 1'b1;
						laneTxD[l]     = sataTx[l%2];
					end
				end
				lane_mux_pkg::SEL_DP: begin
					// Even lanes carry DP1, odd lanes DP0
					if (!dpSeen[(l+1)%2]) begin
						laneLegal[l]       = 1'b1;
						dpSeen[(l+1)%2]    = 1'b1;
						laneTxD[l]         = dpTx[(l+1)%2];
					end
				end
				lane_mux_pkg::SEL_USB0: begin
					if (l < 3 && !usb0Seen) begin
						laneLegal[l] = 1'b1;
						usb0Seen     = 1'b1;
						laneTxD[l]   = usbTx[0];
					end
				end
				lane_mux_pkg::SEL_USB1: begin
					if (l == 3) begin
						laneLegal[l] = 1'b1;
						laneTxD[l]   = usbTx[1];
					end
				end
				lane_mux_pkg::SEL_SGMII: begin
					laneLegal[l] = 1'b1;
					laneTxD[l]   = sgmiiTx[l];
				end
				default: begin
					laneLegal[l] = 1'b0;
				end
			endcase
			laneRefused[l] = (sel_q[l] != lane_mux_pkg::SEL_IDLE)
				&& !laneLegal[l];
		end
	end

	// ==========================================================
	// Receive steering, lane to owning controller
	lane_mux_pkg::lane_word_t [3:0] pcieRxD;
	lane_mux_pkg::lane_word_t [1:0] sataRxD;
	lane_mux_pkg::lane_word_t [1:0] usbRxD;
	lane_mux_pkg::lane_word_t [3:0] sgmiiRxD;

	always_comb begin
		pcieRxD  = '0;
		sataRxD  = '0;
		usbRxD   = '0;
		sgmiiRxD = '0;
		for (int l = 0; l < 4; l++) begin
			if (laneLegal[l]) begin
				case (sel_q[l])
					lane_mux_pkg::SEL_PCIE:  pcieRxD[l]    = laneRx[l];
					lane_mux_pkg::SEL_SATA:  sataRxD[l%2]  = laneRx[l];
					lane_mux_pkg::SEL_USB0:  usbRxD[0]     = laneRx[l];
					lane_mux_pkg::SEL_USB1:  usbRxD[1]     = laneRx[l];
					lane_mux_pkg::SEL_SGMII: sgmiiRxD[l]   = laneRx[l];
					// DP has no receive path
					default: begin
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Output registers
	always_ff @(posedge clk) begin
		if (rst) begin
			laneTx     <= '0;
			laneActive <= '0;
		end else begin
			laneTx     <= laneTxD;
			laneActive <= laneLegal;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pcieRx  <= '0;
			sataRx  <= '0;
			usbRx   <= '0;
			sgmiiRx <= '0;
		end else begin
			pcieRx  <= pcieRxD;
			sataRx  <= sataRxD;
			usbRx   <= usbRxD;
			sgmiiRx <= sgmiiRxD;
		end
	end

	// ==========================================================
	// Checks
	a_pcie_lane_map: assert property (
		@(posedge clk) disable iff (rst)
		(laneLegal[1] && sel_q[1] == lane_mux_pkg::SEL_PCIE)
		|=> laneTx[1] == $past(pcieTx[1]))
		else $error("PCIe lane 1 not on transceiver lane 1");

	a_sata_placement: assert property (
		@(posedge clk) disable iff (rst)
		(sel_q[0] == lane_mux_pkg::SEL_SATA)
		|=> laneActive[0] && laneTx[0] == $past(sataTx[0])
			&& !($past(sel_q[2]) == lane_mux_pkg::SEL_SATA && laneActive[2]))
		else $error("SATA channel 0 placement wrong");

	a_dp_lane_swap: assert property (
		@(posedge clk) disable iff (rst)
		(sel_q[1] == lane_mux_pkg::SEL_DP)
		|=> laneTx[1] == $past(dpTx[0]) && laneActive[1]
			&& ($past(sel_q[3]) == lane_mux_pkg::SEL_SATA || sataRx[1] == '0))
		else $error("DP lane 0 not on transceiver lane 1");

	a_usb_lane_limit: assert property (
		@(posedge clk) disable iff (rst)
		(sel_q[3] == lane_mux_pkg::SEL_USB0)
		|=> !laneActive[3] && laneTx[3] == '0)
		else $error("First USB3 routed to lane 3");

	a_usb1_lane3: assert property (
		@(posedge clk) disable iff (rst)
		(sel_q[0] == lane_mux_pkg::SEL_USB1)
		|=> !laneActive[0] && ($past(sel_q[3]) == lane_mux_pkg::SEL_USB1
			|| usbRx[1] == '0))
		else $error("Second USB3 routed off lane 3");

	a_sgmii_own_lane: assert property (
		@(posedge clk) disable iff (rst)
		(sel_q[2] == lane_mux_pkg::SEL_SGMII)
		|=> laneTx[2] == $past(sgmiiTx[2]) && sgmiiRx[2] == $past(laneRx[2]))
		else $error("SGMII port 2 not on lane 2");

	a_select_write: assert property (
		@(posedge clk) disable iff (rst)
		(regWr && regAddr == lane_mux_pkg::ADDR_SEL)
		##1 (regRd && regAddr == lane_mux_pkg::ADDR_SEL && !regWr)
		|=> regRdata[15:0] == $past(regWdata[15:0], 2))
		else $error("Select register readback wrong");

	a_idle_lane_quiet: assert property (
		@(posedge clk) disable iff (rst)
		!laneLegal[0] |=> laneTx[0] == '0 && !laneActive[0])
		else $error("Idle lane drives data");

	a_active_count: assert property (
		@(posedge clk) disable iff (rst)
		$countones({pcieRx[0].valid, pcieRx[1].valid, pcieRx[2].valid,
			pcieRx[3].valid, sataRx[0].valid, sataRx[1].valid,
			usbRx[0].valid, usbRx[1].valid, sgmiiRx[0].valid,
			sgmiiRx[1].valid, sgmiiRx[2].valid, sgmiiRx[3].valid})
			<= $countones(laneActive))
		else $error("More receive routes than active lanes");

	a_read_timing: assert property (
		@(posedge clk) disable iff (rst)
		!regRd |=> regRdata == '0)
		else $error("Read data outside read cycle");

	a_pcie_lane_zero: assert property (
		@(posedge clk) disable iff (rst)
		(sel_q[0] == lane_mux_pkg::SEL_PCIE)
		|=> laneActive[0] && laneTx[0] == $past(pcieTx[0])
			&& pcieRx[0] == $past(laneRx[0]))
		else $error("PCIe lane 0 not on transceiver lane 0");

	a_pcie_lane_three: assert property (
		@(posedge clk) disable iff (rst)
		(sel_q[3] == lane_mux_pkg::SEL_PCIE)
		|=> laneActive[3] && laneTx[3] == $past(pcieTx[3])
			&& pcieRx[3] == $past(laneRx[3]))
		else $error("PCIe lane 3 not on transceiver lane 3");

	a_sata_chan_one: assert property (
		@(posedge clk) disable iff (rst)
		(sel_q[1] == lane_mux_pkg::SEL_SATA)
		|=> laneActive[1] && laneTx[1] == $past(sataTx[1])
			&& sataRx[1] == $past(laneRx[1]))
		else $error("SATA channel 1 not on lane 1");

	a_dp_even_lane: assert property (
		@(posedge clk) disable iff (rst)
		(sel_q[0] == lane_mux_pkg::SEL_DP)
		|=> laneActive[0] && laneTx[0] == $past(dpTx[1]))
		else $error("DP lane 1 not on transceiver lane 0");

	a_dp_no_receive: assert property (
		@(posedge clk) disable iff (rst)
		(sel_q[0] == lane_mux_pkg::SEL_DP)
		|=> pcieRx[0] == '0 && sgmiiRx[0] == '0)
		else $error("DP lane feeds a receive output");

	a_usb0_first_lane: assert property (
		@(posedge clk) disable iff (rst)
		(sel_q[2] == lane_mux_pkg::SEL_USB0
			&& sel_q[0] != lane_mux_pkg::SEL_USB0
			&& sel_q[1] != lane_mux_pkg::SEL_USB0)
		|=> laneActive[2] && laneTx[2] == $past(usbTx[0])
			&& usbRx[0] == $past(laneRx[2]))
		else $error("First USB3 not on lane 2");

	a_usb1_on_lane3: assert property (
		@(posedge clk) disable iff (rst)
		(sel_q[3] == lane_mux_pkg::SEL_USB1)
		|=> laneActive[3] && laneTx[3] == $past(usbTx[1])
			&& usbRx[1] == $past(laneRx[3]))
		else $error("Second USB3 not on lane 3");

	a_sgmii_lane_zero: assert property (
		@(posedge clk) disable iff (rst)
		(sel_q[0] == lane_mux_pkg::SEL_SGMII)
		|=> laneActive[0] && laneTx[0] == $past(sgmiiTx[0])
			&& sgmiiRx[0] == $past(laneRx[0]))
		else $error("SGMII port 0 not on lane 0");

	a_refused_lane_idle: assert property (
		@(posedge clk) disable iff (rst)
		(sel_q[3] > lane_mux_pkg::SEL_SGMII)
		|=> !laneActive[3] && laneTx[3] == '0)
		else $error("Unknown select drives lane 3");

	a_status_read: assert property (
		@(posedge clk) disable iff (rst)
		(regRd && regAddr == lane_mux_pkg::ADDR_STAT)
		|=> regRdata[3:0] == $past(laneActive)
			&& regRdata[31:8] == '0)
		else $error("Status read does not show active lanes");

endmodule : high_speed_lane_mux

`default_nettype wire

// [verif/lane_model.sv]
// Transceiver lane model: echoes transmit words back with inverted data plus the lane number
`timescale 1ns/1ps
`default_nettype none
module lane_model (
	input  wire logic                           clk,    // Clock
	input  wire lane_mux_pkg::lane_word_t [3:0] laneTx, // From mux
	output lane_mux_pkg::lane_word_t      [3:0] laneRx  // To mux
);
	// ==========================================================
	// Inverted echo, so a stale word never passes for fresh data
	initial laneRx = '0;
	always @(posedge clk) begin
		for (int n = 0; n < 4; n++) begin
			laneRx[n] <= {laneTx[n].valid, ~laneTx[n].data + 16'(n)};
		end
	end
endmodule : lane_model
`default_nettype wire

// [verif/testbench.sv]
// Testbench: lane selection, status and register port of the lane mux
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                           clk = 0;
	logic                           rst = 1;
	logic                           regWr = 0;
	logic                           regRd = 0;
	logic [7:0]                     regAddr = '0;
	logic [31:0]                    regWdata = '0;
	logic [31:0]                    regRdata;
	logic [31:0]                    d;
	lane_mux_pkg::lane_word_t [3:0] pcieTx, sgmiiTx, pcieRx, sgmiiRx;
	lane_mux_pkg::lane_word_t [3:0] laneTx, laneRx;
	lane_mux_pkg::lane_word_t [1:0] sataTx, dpTx, usbTx, sataRx, usbRx;
	logic [3:0]                     laneActive;
	int                             failures = 0;
	int                             num_checks = 0;
	int                             cyc = 0;

	high_speed_lane_mux dut (.clk(clk), .rst(rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .pcieTx(pcieTx), .sataTx(sataTx),
		.dpTx(dpTx), .usbTx(usbTx), .sgmiiTx(sgmiiTx), .pcieRx(pcieRx),
		.sataRx(sataRx), .usbRx(usbRx), .sgmiiRx(sgmiiRx),
		.laneTx(laneTx), .laneRx(laneRx), .laneActive(laneActive));
	lane_model model (.clk(clk), .laneTx(laneTx), .laneRx(laneRx));

	// ==========================================================
	// Shared tasks
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask : rd
	task automatic settle;
		repeat (4) @(posedge clk);
		#1;
	endtask : settle
	function automatic lane_mux_pkg::lane_word_t src(int n, logic [3:0] c);
		case (c)
			lane_mux_pkg::SEL_PCIE:  return pcieTx[n];
			lane_mux_pkg::SEL_SATA:  return sataTx[n % 2];
			lane_mux_pkg::SEL_DP:    return dpTx[(n + 1) % 2];
			lane_mux_pkg::SEL_USB0:  return n < 3 ? usbTx[0] : '0;
			lane_mux_pkg::SEL_USB1:  return n == 3 ? usbTx[1] : '0;
			lane_mux_pkg::SEL_SGMII: return sgmiiTx[n];
			default:                 return '0;
		endcase
	endfunction : src
	function automatic lane_mux_pkg::lane_word_t rxOf(int n, logic [3:0] c);
		case (c)
			lane_mux_pkg::SEL_PCIE: return pcieRx[n];
			lane_mux_pkg::SEL_SATA: return sataRx[n % 2];
			lane_mux_pkg::SEL_USB0: return usbRx[0];
			lane_mux_pkg::SEL_USB1: return usbRx[1];
			default:                return sgmiiRx[n];
		endcase
	endfunction : rxOf

	// ==========================================================
	// Scenarios
	task automatic test_reset;
		rd(lane_mux_pkg::ADDR_SEL, d);
		chk(d, 32'h0000_0000);
		chk(32'(laneActive), 32'h0000_0000);
	endtask : test_reset
	task automatic test_lane_codes;
		lane_mux_pkg::lane_word_t e;
		logic [31:0]              act;
		logic [31:0]              refu;
		for (int n = 0; n < 4; n++) begin
			for (int c = 0; c < 16; c++) begin
				wr(lane_mux_pkg::ADDR_SEL, 32'(c) << (4 * n));
				settle();
				e = src(n, 4'(c));
				act = (e !== '0) ? 32'(1) << n : 32'h0000_0000;
				refu = (c != 0 && e === '0) ? 32'(16) << n : 32'h0000_0000;
				chk(32'(laneTx[n]), 32'(e));
				chk(32'(laneActive), act);
				if (e !== '0 && c != 3)
					chk(32'(rxOf(n, 4'(c))), 32'(laneRx[n]));
				rd(lane_mux_pkg::ADDR_STAT, d);
				chk(d, act | refu);
			end
		end
	endtask : test_lane_codes
	task automatic test_full;
		logic [15:0] sel [4] = '{16'h6666, 16'h5111, 16'h3333, 16'h0202};
		logic [7:0]  st [4]  = '{8'h0F, 8'h0F, 8'hC3, 8'h41};
		for (int i = 0; i < 4; i++) begin
			wr(lane_mux_pkg::ADDR_SEL, 32'(sel[i]));
			settle();
			rd(lane_mux_pkg::ADDR_STAT, d);
			chk(d, 32'(st[i]));
			if (i == 2) begin
				chk(32'(laneTx[0]), 32'(dpTx[1]));
				chk(32'(laneTx[1]), 32'(dpTx[0]));
				chk(32'(laneTx[2]), 32'h0000_0000);
			end
		end
		chk(32'(laneTx[0]), 32'(sataTx[0]));
	endtask : test_full
	task automatic test_regs;
		wr(lane_mux_pkg::ADDR_SEL, 32'h1234_6666);
		wr(8'h08, 32'h0000_0000);
		wr(lane_mux_pkg::ADDR_STAT, 32'h0000_0000);
		rd(lane_mux_pkg::ADDR_SEL, d);
		chk(d, 32'h0000_6666);
		rd(8'h08, d);
		chk(d, 32'h0000_0000);
		@(posedge clk);
		#1 chk(regRdata, 32'h0000_0000);
		// Write then read with no gap between strobes
		@(posedge clk);
		regAddr <= lane_mux_pkg::ADDR_SEL;
		regWdata <= 32'h0000_4321;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 chk(regRdata, 32'h0000_4321);
	endtask : test_regs

	// ==========================================================
	// Run control
	task automatic end_sim;
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			end_sim();
		end
	end
	initial begin
		for (int i = 0; i < 4; i++) begin
			pcieTx[i] = {1'b1, 16'h1000 + 16'(i)};
			sgmiiTx[i] = {1'b1, 16'h6000 + 16'(i)};
		end
		for (int i = 0; i < 2; i++) begin
			sataTx[i] = {1'b1, 16'h2000 + 16'(i)};
			dpTx[i] = {1'b1, 16'h3000 + 16'(i)};
			usbTx[i] = {1'b1, 16'h4000 + 16'(i)};
		end
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		test_reset();
		test_lane_codes();
		test_full();
		test_regs();
		end_sim();
	end
endmodule : testbench
`default_nettype wire
